// *** include/cct_pkg.sv ***
// Constants and carrier types of the capture and compare timer control.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone slave port.
package cct_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_COUNT = 8'h0C;
  localparam logic [7:0] ADR_CMP0  = 8'h28;
  localparam logic [7:0] ADR_CMP1  = 8'h2C;
  localparam logic [7:0] ADR_STAT  = 8'h34;
  localparam logic [7:0] ADR_MASK  = 8'h38;

  // ****************************************
  // Control register field positions
  // ****************************************
  localparam int B_ACT   = 0;
  localparam int B_EN    = 1;
  localparam int B_FRST  = 2;
  localparam int B_SEL   = 4;
  localparam int B_ON0   = 8;
  localparam int B_ON1   = 9;
  localparam int B_SET1  = 16;
  localparam int B_SET0  = 17;
  localparam int B_CLR1  = 24;
  localparam int B_CLR0  = 25;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] CMP_RST   = 32'h0000_0000;
  localparam logic [2:0]  SEL_RST   = 3'h0;
  localparam logic [1:0]  IRQ_RST   = 2'h0;

  // ****************************************
  // Timing: 48 MHz base from the 125 MHz clock
  // ****************************************
  localparam int SRC_KHZ = 48000;
  localparam int SYS_KHZ = 125000;
  localparam logic [7:0] ACC_STEP = 8'(SRC_KHZ / 1000);
  localparam logic [7:0] ACC_WRAP = 8'(SYS_KHZ / 1000);

  // Captured bus request
  typedef struct packed {
    logic [7:0]  adr;
    logic        we;
    logic [31:0] dat;
    logic [31:0] lanes;
  } cct_req_t;

  // Software commands for one compare channel
  typedef struct packed {
    logic on;
    logic force_hi;
    logic force_lo;
  } cct_chan_ctl_t;

endpackage

// *** hw/cct_timebase.sv ***
// Counter time base: 48 MHz phase accumulator and power-of-two divider.
// Assumes the caller holds run_i low while the block is gated.
`timescale 1ns/1ps
`default_nettype none
module cct_timebase (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [2:0] sel_i,
  // Advance pulse
  output logic            tick_o
);
  logic [7:0] acc;
  logic [6:0] div;
  logic [7:0] acc_sum;
  logic       base;
  logic [6:0] div_mask;

  // Accumulator overflow marks a 48 MHz edge
  assign acc_sum  = acc + cct_pkg::ACC_STEP;
  assign base     = acc_sum >= cct_pkg::ACC_WRAP;
  assign div_mask = ~(7'h7F << sel_i);

  // Accumulator, divider and tick; upper select half gives no ticks
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      acc    <= 8'h00;
      div    <= 7'h00;
      tick_o <= 1'b0;
    end else begin
      acc    <= base ? acc_sum - cct_pkg::ACC_WRAP : acc_sum;
      div    <= base ? div + 7'h01 : div;
      tick_o <= base && !sel_i[2] && ((div & div_mask) == div_mask);
    end
  end
endmodule
`default_nettype wire

// *** hw/cct_cmp_chan.sv ***
// One compare channel: toggle flip-flop, software force and match event.
// Assumes moved_i pulses once per new counter value.
`timescale 1ns/1ps
`default_nettype none
module cct_cmp_chan (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Control and values
  input  wire cct_pkg::cct_chan_ctl_t ctl_i,
  input  wire logic                  active_i,
  input  wire logic                  moved_i,
  input  wire logic [31:0]           count_i,
  input  wire logic [31:0]           cmp_i,
  // Outputs
  output logic                       out_o,
  output logic                       evt_o
);
  logic hit;
  logic next_out;

  // Match only on a fresh count while enabled and active
  assign hit = ctl_i.on && active_i && moved_i && (count_i == cmp_i);

  // Force high beats force low, software beats toggle
  assign next_out = ctl_i.force_hi ? 1'b1 :
                    ctl_i.force_lo ? 1'b0 :
                    hit            ? ~out_o : out_o;

  // Output flip-flop and event pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_o <= 1'b0;
      evt_o <= 1'b0;
    end else begin
      out_o <= next_out;
      evt_o <= hit;
    end
  end
endmodule
`default_nettype wire

// *** hw/cct_timer_top.sv ***
// Capture and compare timer control: counter, time base, two compares.
// Assumes a classic Wishbone master, one clock at 125 MHz, sync reset.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cct_timer_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Timer outputs
  output logic             cmp_toggle_out0_o,
  output logic             cmp_toggle_out1_o,
  output logic             cmp_evt0_o,
  output logic             cmp_evt1_o,
  output logic [31:0]      count_o,
  output logic             irq_o
);

  // ****************************************
  // Control and data state
  // ****************************************
  logic        activate;
  logic        cnt_enable;
  logic        cnt_reset;
  logic [2:0]  counter_clock_select;
  logic        cmp_chan0_on;
  logic        cmp_chan1_on;
  logic [31:0] cmp0;
  logic [31:0] cmp1;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic        moved;
  logic        tick;

  // ****************************************
  // Bus decode
  // ****************************************
  cct_pkg::cct_req_t req;
  cct_pkg::cct_chan_ctl_t ctl0;
  cct_pkg::cct_chan_ctl_t ctl1;
  logic        take;
  logic        wr;
  logic        wr_ctrl;
  logic        wr_cnt;
  logic        wr_cmp0;
  logic        wr_cmp1;
  logic        wr_mask;
  logic        rd_stat;
  logic        cmp_out0_force_high;
  logic        cmp_out1_force_high;
  logic        cmp_out0_force_low;
  logic        cmp_out1_force_low;
  logic        hit_any;
  logic [31:0] ctrl_rd;
  logic [31:0] rdata;
  logic [31:0] next_count;
  logic [1:0]  next_stat;

  // Request capture and byte-lane mask
  assign req.adr   = wb_adr_i;
  assign req.we    = wb_we_i;
  assign req.dat   = wb_dat_i;
  assign req.lanes = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // A request is taken once, in the cycle before its ack
  assign take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr      = take && req.we;
  assign wr_ctrl = wr && (req.adr == cct_pkg::ADR_CTRL);
  assign wr_cnt  = wr && (req.adr == cct_pkg::ADR_COUNT);
  assign wr_cmp0 = wr && (req.adr == cct_pkg::ADR_CMP0);
  assign wr_cmp1 = wr && (req.adr == cct_pkg::ADR_CMP1);
  assign wr_mask = wr && (req.adr == cct_pkg::ADR_MASK);
  assign rd_stat = take && !req.we && (req.adr == cct_pkg::ADR_STAT);

  // Write-one-to-set and write-one-to-clear fields of the control register
  assign cmp_out0_force_high = wr_ctrl && req.lanes[cct_pkg::B_SET0]
                               && req.dat[cct_pkg::B_SET0];
  assign cmp_out1_force_high = wr_ctrl && req.lanes[cct_pkg::B_SET1]
                               && req.dat[cct_pkg::B_SET1];
  assign cmp_out0_force_low  = wr_ctrl && req.lanes[cct_pkg::B_CLR0]
                               && req.dat[cct_pkg::B_CLR0] && !cmp_out0_force_high;
  assign cmp_out1_force_low  = wr_ctrl && req.lanes[cct_pkg::B_CLR1]
                               && req.dat[cct_pkg::B_CLR1] && !cmp_out1_force_high;

  // Channel command bundles
  assign ctl0 = '{on: cmp_chan0_on, force_hi: cmp_out0_force_high,
                  force_lo: cmp_out0_force_low};
  assign ctl1 = '{on: cmp_chan1_on, force_hi: cmp_out1_force_high,
                  force_lo: cmp_out1_force_low};

  assign ctrl_rd = {6'h00, cmp_toggle_out0_o, cmp_toggle_out1_o,
                    6'h00, cmp_toggle_out0_o, cmp_toggle_out1_o,
                    6'h00, cmp_chan1_on, cmp_chan0_on,
                    1'b0, counter_clock_select,
                    1'b0, cnt_reset, cnt_enable, activate};

  // Read multiplexer; unmapped offsets read zero
  assign rdata = (req.adr == cct_pkg::ADR_CTRL)  ? ctrl_rd :
                 (req.adr == cct_pkg::ADR_COUNT) ? count_o :
                 (req.adr == cct_pkg::ADR_CMP0)  ? cmp0 :
                 (req.adr == cct_pkg::ADR_CMP1)  ? cmp1 :
                 (req.adr == cct_pkg::ADR_STAT)  ? {30'h0000_0000, irq_stat} :
                 (req.adr == cct_pkg::ADR_MASK)  ? {30'h0000_0000, irq_mask} :
                 32'h0000_0000;

  // Bus answer one cycle after a request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= take;
      wb_dat_o <= take ? rdata : wb_dat_o;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // all fields reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      activate             <= 1'b0;
      cnt_enable           <= 1'b0;
      cnt_reset            <= 1'b0;
      counter_clock_select <= cct_pkg::SEL_RST;
      cmp_chan0_on         <= 1'b0;
      cmp_chan1_on         <= 1'b0;
    end else if (cnt_reset) begin
      cnt_reset  <= 1'b0;
      cnt_enable <= 1'b0;
    end else if (wr_ctrl) begin
      if (req.lanes[0]) begin
        activate             <= req.dat[cct_pkg::B_ACT];
        cnt_enable           <= req.dat[cct_pkg::B_EN];
        cnt_reset            <= req.dat[cct_pkg::B_FRST];
        counter_clock_select <= req.dat[cct_pkg::B_SEL +: 3];
      end
      if (req.lanes[8]) begin
        cmp_chan0_on <= req.dat[cct_pkg::B_ON0];
        cmp_chan1_on <= req.dat[cct_pkg::B_ON1];
      end
    end
  end

  // ****************************************
  // Time base and free-running counter
  // ****************************************
  // select drives base
  cct_timebase u_base (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (activate && cnt_enable && !cnt_reset),
    .sel_i  (counter_clock_select),
    .tick_o (tick)
  );

  assign next_count = cnt_reset ? cct_pkg::COUNT_RST :
                      (wr_cnt && !cnt_enable) ?
                        ((count_o & ~req.lanes) | (req.dat & req.lanes)) :
                      (tick && cnt_enable && activate) ? count_o + 32'h0000_0001 :
                      count_o;

  // Counter and its change flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= cct_pkg::COUNT_RST;
      moved   <= 1'b0;
    end else begin
      count_o <= next_count;
      moved   <= next_count != count_o;
    end
  end

  // Compare values, writable at any time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp0 <= cct_pkg::CMP_RST;
      cmp1 <= cct_pkg::CMP_RST;
    end else begin
      cmp0 <= wr_cmp0 ? (cmp0 & ~req.lanes) | (req.dat & req.lanes) : cmp0;
      cmp1 <= wr_cmp1 ? (cmp1 & ~req.lanes) | (req.dat & req.lanes) : cmp1;
    end
  end

  // ****************************************
  // Compare channels
  // ****************************************
  // channel 0 match
  cct_cmp_chan u_chan0 (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ctl_i    (ctl0),
    .active_i (activate),
    .moved_i  (moved),
    .count_i  (count_o),
    .cmp_i    (cmp0),
    .out_o    (cmp_toggle_out0_o),
    .evt_o    (cmp_evt0_o)
  );

  cct_cmp_chan u_chan1 (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ctl_i    (ctl1),
    .active_i (activate),
    .moved_i  (moved),
    .count_i  (count_o),
    .cmp_i    (cmp1),
    .out_o    (cmp_toggle_out1_o),
    .evt_o    (cmp_evt1_o)
  );

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  // Event set wins over read clear
  assign next_stat = (rd_stat ? 2'h0 : irq_stat) | {cmp_evt1_o, cmp_evt0_o};
  assign hit_any   = |(next_stat & irq_mask);

  // Status, mask and level output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= cct_pkg::IRQ_RST;
      irq_mask <= cct_pkg::IRQ_RST;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      irq_mask <= (wr_mask && req.lanes[0]) ? req.dat[1:0] : irq_mask;
      irq_o    <= hit_any;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_timing: assert property (take |=> wb_ack_o)
    else $error("ack missing one cycle after request");

  a_set0_high: assert property (cmp_out0_force_high |=> cmp_toggle_out0_o)
    else $error("set 0 did not drive output 0 high");

  a_set1_high: assert property (cmp_out1_force_high |=> cmp_toggle_out1_o)
    else $error("set 1 did not drive output 1 high");

  a_clear_low: assert property (
    wr_ctrl && req.lanes[cct_pkg::B_CLR0] && req.dat[cct_pkg::B_CLR0]
    |=> (cmp_toggle_out0_o == $past(req.dat[cct_pkg::B_SET0]
                                    && req.lanes[cct_pkg::B_SET0])))
    else $error("clear 0 mishandled against set 0");

  a_evt0_cause: assert property (
    cmp_evt0_o |-> $past(cmp_chan0_on && activate && moved
                         && count_o == cmp0))
    else $error("event 0 without enabled match");

  a_evt1_toggle: assert property (
    cmp_evt1_o && !$past(cmp_out1_force_high || cmp_out1_force_low)
    |-> cmp_toggle_out1_o != $past(cmp_toggle_out1_o))
    else $error("match 1 did not toggle output 1");

  a_reset_done: assert property (
    cnt_reset |=> !cnt_reset && !cnt_enable && count_o == 32'h0000_0000)
    else $error("counter reset cycle did not complete");

  a_count_step: assert property (
    tick && cnt_enable && activate && !cnt_reset
    |=> count_o == $past(count_o) + 32'h0000_0001)
    else $error("count did not advance on tick");

  a_count_ro: assert property (
    wr_cnt && cnt_enable && !tick && !cnt_reset |=> $stable(count_o))
    else $error("count changed by a write while enabled");

  a_sel_gated: assert property (
    (counter_clock_select[2] || !activate) ##1
    (counter_clock_select[2] || !activate) |-> !tick)
    else $error("tick while reserved select or inactive");

  c_reset_cycle: cover property (wr_ctrl && req.dat[cct_pkg::B_FRST] ##1 cnt_reset);
  c_evt0:        cover property (cmp_evt0_o);
  c_evt1:        cover property (cmp_evt1_o);
  c_irq:         cover property ($rose(irq_o));

endmodule
`default_nettype wire

// *** sim/cct_agg_model.sv ***
// Interrupt aggregator model: counts compare event pulses per channel.
// Assumes the events are one-cycle pulses on the system clock.
`timescale 1ns/1ps
`default_nettype none
module cct_agg_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Compare events
  input  wire logic evt0_i,
  input  wire logic evt1_i,
  // Event tallies
  output var int    evt0_cnt_o,
  output var int    evt1_cnt_o
);
  // ****************************************
  // Event tallies
  // ****************************************
  // Count each pulse once, as the aggregator latches it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt0_cnt_o <= 0;
      evt1_cnt_o <= 0;
    end else begin
      evt0_cnt_o <= evt0_cnt_o + int'(evt0_i);
      evt1_cnt_o <= evt1_cnt_o + int'(evt1_i);
    end
  end
endmodule
`default_nettype wire

// *** sim/capture_compare_timer_control_test.sv ***
// Self-checking bench for the compare timer control over classic Wishbone.
// Assumes the design acks each request one cycle after taking it.
`timescale 1ns/1ps
`default_nettype none
module capture_compare_timer_control_test;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_rdat, count, c;
  logic        out0, out1, evt0, evt1, irq;
  int          err_total, check_count, evt0_cnt, evt1_cnt;

  cct_timer_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .cmp_toggle_out0_o(out0),
    .cmp_toggle_out1_o(out1), .cmp_evt0_o(evt0), .cmp_evt1_o(evt1),
    .count_o(count), .irq_o(irq));
  cct_agg_model AGG (.clk_i(clk_i), .rst_i(rst_i), .evt0_i(evt0), .evt1_i(evt1),
    .evt0_cnt_o(evt0_cnt), .evt1_cnt_o(evt1_cnt));

  // ****************************************
  // Clock, watchdog and verdict
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end
  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Compare tasks
  // ****************************************
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      $display("[FAIL] t=%0t got=%h lo=%h hi=%h", $time, got, lo, hi);
      err_total++;
    end
  endtask

  // ****************************************
  // Bus cycles
  // ****************************************
  // One classic cycle; held until ack is sampled high
  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= w; wb_adr <= a; wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_rdat;
    if (n >= 50) chk_val(32'h0000_0000, 32'hFFFF_FFFF);
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(a, 1'b1, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(a, 1'b0, 32'h0000_0000, q);
    chk_val(q, exp);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb_xfer(a, 1'b0, 32'h0000_0000, q);
  endtask
  // Wait, bounded, until the count reaches a value
  task automatic wait_cnt(input logic [31:0] v);
    for (int n = 0; n < 2000 && count < v; n++) @(posedge clk_i);
    chk_rng(count, v, 32'hFFFF_FFFF);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    err_total = 0; check_count = 0;
    wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 8'h00; wb_dat = 32'h0000_0000;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(cct_pkg::ADR_CTRL, 32'h0000_0000);
    rd_chk(cct_pkg::ADR_COUNT, 32'h0000_0000);
    rd_chk(cct_pkg::ADR_STAT, 32'h0000_0000);
    rd_chk(cct_pkg::ADR_MASK, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    wr(cct_pkg::ADR_CTRL, 32'hFC3C_8888);
    rd_chk(cct_pkg::ADR_CTRL, 32'h0000_0000);
    // Forces: set wins over clear of the same channel
    wr(cct_pkg::ADR_CTRL, 32'h0002_0000);
    rd_chk(cct_pkg::ADR_CTRL, 32'h0202_0000);
    chk_val({31'h0, out0}, 32'h0000_0001);
    wr(cct_pkg::ADR_CTRL, 32'h0001_0000);
    rd_chk(cct_pkg::ADR_CTRL, 32'h0303_0000);
    wr(cct_pkg::ADR_CTRL, 32'h0200_0000);
    rd_chk(cct_pkg::ADR_CTRL, 32'h0101_0000);
    wr(cct_pkg::ADR_CTRL, 32'h0101_0000);
    rd_chk(cct_pkg::ADR_CTRL, 32'h0101_0000);
    wr(cct_pkg::ADR_CTRL, 32'h0100_0000);
    chk_val({31'h0, out1}, 32'h0000_0000);
    // Count written while stopped, then held under a reserved select
    wr(cct_pkg::ADR_COUNT, 32'hFFFF_FFFE);
    rd_chk(cct_pkg::ADR_COUNT, 32'hFFFF_FFFE);
    wr(cct_pkg::ADR_CTRL, 32'h0000_0043);
    repeat (100) @(posedge clk_i);
    rd_chk(cct_pkg::ADR_COUNT, 32'hFFFF_FFFE);
    wr(cct_pkg::ADR_COUNT, 32'h0000_0055);
    rd_chk(cct_pkg::ADR_COUNT, 32'hFFFF_FFFE);
    // Run across the wrap, then stop and hold
    wr(cct_pkg::ADR_CTRL, 32'h0000_0003);
    repeat (20) @(posedge clk_i);
    wr(cct_pkg::ADR_CTRL, 32'h0000_0001);
    rd(cct_pkg::ADR_COUNT, c);
    chk_rng(c, 32'h0000_0004, 32'h0000_0009);
    repeat (50) @(posedge clk_i);
    rd_chk(cct_pkg::ADR_COUNT, c);
    wr(cct_pkg::ADR_CTRL, 32'h0000_0002);
    repeat (50) @(posedge clk_i);
    rd_chk(cct_pkg::ADR_COUNT, c);
    // Tick rate of 48 MHz over two to the select
    for (int k = 0; k < 3; k++) begin
      wr(cct_pkg::ADR_CTRL, 32'h0000_0001);
      wr(cct_pkg::ADR_COUNT, 32'h0000_0000);
      wr(cct_pkg::ADR_CTRL, 32'h0000_0003 | (32'(k) << 4));
      repeat (1000) @(posedge clk_i);
      wr(cct_pkg::ADR_CTRL, 32'h0000_0001);
      rd(cct_pkg::ADR_COUNT, c);
      chk_rng(c, (32'h0000_0180 >> k) - 2, (32'h0000_0181 >> k) + 2);
    end
    // Counter reset with software polling its bit
    wr(cct_pkg::ADR_CTRL, 32'h0000_0003);
    repeat (10) @(posedge clk_i);
    wr(cct_pkg::ADR_CTRL, 32'h0000_0007);
    c = 32'h0000_0004;
    for (int n = 0; n < 10 && c[2] !== 1'b0; n++) rd(cct_pkg::ADR_CTRL, c);
    chk_val(c, 32'h0000_0001);
    repeat (20) @(posedge clk_i);
    rd_chk(cct_pkg::ADR_COUNT, 32'h0000_0000);
    rd_chk(cct_pkg::ADR_CTRL, 32'h0000_0001);
    // Compare matches, masked and unmasked interrupt
    wr(cct_pkg::ADR_MASK, 32'h0000_0002);
    wr(cct_pkg::ADR_CMP0, 32'h0000_0014);
    wr(cct_pkg::ADR_CMP1, 32'h0000_003C);
    rd_chk(cct_pkg::ADR_CMP0, 32'h0000_0014);
    wr(cct_pkg::ADR_CTRL, 32'h0000_0303);
    wait_cnt(32'h0000_0028);
    chk_val({31'h0, out0}, 32'h0000_0001);
    chk_val({31'h0, irq}, 32'h0000_0000);
    wait_cnt(32'h0000_0046);
    wr(cct_pkg::ADR_CTRL, 32'h0000_0301);
    chk_val({31'h0, out1}, 32'h0000_0001);
    chk_val(32'(evt0_cnt), 32'h0000_0001);
    chk_val(32'(evt1_cnt), 32'h0000_0001);
    chk_val({31'h0, irq}, 32'h0000_0001);
    rd_chk(cct_pkg::ADR_STAT, 32'h0000_0003);
    repeat (3) @(posedge clk_i);
    chk_val({31'h0, irq}, 32'h0000_0000);
    rd_chk(cct_pkg::ADR_STAT, 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
